//--- rtl/spi_eeprom_pkg.sv
// constants, carrier types and decode helpers for the serial eeprom slave
// assumes a 100 MHz system clock; pins arrive asynchronous to it
// Overview of operation
// - input bits sampled on rising serial clock
// - output changes on falling serial clock edge
// - chip select high: output off, standby
// - protect pin low plus guard refuses status
// - first byte is opcode, unknown ones ignored
// - opcodes for latch set, clear, status write
// - opcodes for status read, array read, write
// - busy flag high during internal write only
// - latch set and cleared by its commands
// - block guard bits written only by status write
// - status byte field layout fixed
// - small variant block protect address ranges
// - large variant block protect address ranges
// - latch and protect matrix gate all writes
// - latch cleared out of power up
// - write is opcode, 16-bit address, data
// - programming starts at closing select edge
// - while busy only status read accepted
// - page of 32 bytes, offset wraps
// - latch cleared when write cycle ends
// - internal write ends within 5 ms
// - status write alters bits 7, 3, 2 only
// - paused: output off, input ignored

package spi_eeprom_pkg;

	// ****************************************
	// command opcodes
	// ****************************************
	localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
	localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;

	// ****************************************
	// device_status fields and reset values
	// ****************************************
	localparam int PIN_GUARD_ENABLE_POS = 7;
	localparam int BLOCK_GUARD_HI_POS = 3;
	localparam int BLOCK_GUARD_LO_POS = 2;
	localparam int WRITE_LATCH_BIT_POS = 1;
	localparam int BUSY_POS = 0;
	localparam logic PIN_GUARD_RST = 1'b0;
	localparam logic [1:0] BLOCK_GUARD_RST = 2'h0;
	localparam logic WRITE_LATCH_RST = 1'b0;

	// ****************************************
	// array geometry and timing
	// ****************************************
	localparam int MEM_BYTES = 2048;
	localparam int PAGE_BYTES = 32;
	localparam int WRITE_TIME_MS = 5;
	localparam int CLK_HZ = 100000000;
	localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);
	localparam logic [4:0] PINS_IDLE = 5'h13;

	// ****************************************
	// types
	// ****************************************
	// pin bundle, idle: select high, pause high, protect high
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} pins_t;

	// command decoder states
	typedef enum logic [3:0] {
		ST_CMD, ST_SET, ST_CLR, ST_ADDR, ST_RD_ARR, ST_RD_SR,
		ST_WR_SR, ST_SR_DONE, ST_WR_ARR, ST_IGNORE
	} cmd_state_t;

	// keep only the significant address bits of the variant
	function automatic logic [10:0] mask_addr(input logic [15:0] a, input logic big);
		mask_addr = big ? a[10:0] : {1'b0, a[9:0]};
	endfunction : mask_addr

	// block guard code against address, quarter, half or whole array
	function automatic logic is_protected(input logic [10:0] a, input logic [1:0] bp,
		input logic big);
		logic [1:0] top;
		top = big ? a[10:9] : a[9:8];
		case (bp)
			2'h0: is_protected = 1'b0;
			2'h1: is_protected = (top == 2'h3);
			2'h2: is_protected = top[1];
			default: is_protected = 1'b1;
		endcase
	endfunction : is_protected

endpackage : spi_eeprom_pkg

//--- rtl/pin_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
// assumes a synchronous active high reset on the sampling clock
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	// ****************************************
	// synchroniser stages
	// ****************************************
	logic [WIDTH-1:0] meta; // first stage, read only by second

	// each bit gets its own pair of flops
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					meta[i] <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync

`default_nettype wire

//--- rtl/spi_eeprom_command_protect.sv
// serial eeprom slave: shifter, decoder, status, protection, page write
// assumes host drives select, clock, data, pause and protect pins
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_protect #(
	parameter logic big_variant = 1'b1, // 1: 2048 bytes, 0: 1024 bytes
	parameter int write_cycles = spi_eeprom_pkg::WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	output logic so,
	output logic so_oe
);

	// ****************************************
	// pin synchronisation and edges
	// ****************************************
	spi_eeprom_pkg::pins_t raw; // pins as they arrive
	spi_eeprom_pkg::pins_t syn; // pins after two flops
	logic sck_q; // delayed clock for edge find
	logic cs_q; // delayed select for edge find

	assign raw = {cs_n, sck, si, hold_n, wp_n};

	pin_sync #(
		.WIDTH(5),
		.RST_VAL(spi_eeprom_pkg::PINS_IDLE)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(raw),
		.q(syn)
	);

	// edge history flops
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			sck_q <= syn.sck;
			cs_q <= syn.cs_n;
		end
	end

	wire active = !syn.cs_n && syn.hold_n; // selected and not paused
	wire sh_in = active && syn.sck && !sck_q; // sample on rising edge
	wire sh_out = active && !syn.sck && sck_q; // drive on falling edge
	wire cs_rise = syn.cs_n && !cs_q; // frame end

	// ****************************************
	// state and registers
	// ****************************************
	spi_eeprom_pkg::cmd_state_t state; // decoder state
	spi_eeprom_pkg::cmd_state_t next_state; // decoder next state
	logic [3:0] bit_cnt; // bits seen in current field
	logic [15:0] in_sr; // input shifter
	logic [7:0] out_sr; // output shifter
	logic cmd_wr; // address phase belongs to array write
	logic [10:0] rd_ptr; // next byte to read
	logic [10:0] wr_addr; // page and offset of write
	logic [31:0] page_mask; // bytes loaded into page buffer
	logic [7:0] page_buf [spi_eeprom_pkg::PAGE_BYTES]; // page buffer
	logic [7:0] mem [spi_eeprom_pkg::MEM_BYTES]; // array
	logic [7:0] sr_new; // staged status byte
	logic pin_guard; // pin_guard_enable
	logic [1:0] bp; // block_guard_hi, block_guard_lo
	logic latch; // write_latch_bit
	logic busy; // internal write running
	logic kind_arr; // running write is array, not status
	logic [19:0] timer; // internal write cycle counter

	wire [15:0] next_word = {in_sr[14:0], syn.si}; // msb first
	wire [7:0] next_byte = next_word[7:0];
	wire byte_done = sh_in && (bit_cnt[2:0] == 3'h7);
	wire addr_done = sh_in && (bit_cnt == 4'hF);
	wire [10:0] rx_addr = spi_eeprom_pkg::mask_addr(next_word, big_variant);
	wire [10:0] rd_next = spi_eeprom_pkg::mask_addr({5'h00, rd_ptr} + 16'h0001, big_variant);
	wire wr_prot = spi_eeprom_pkg::is_protected(wr_addr, bp, big_variant);
	wire [7:0] status_byte = {pin_guard, 3'h0, bp, latch, busy};
	wire sr_ok = latch && !(pin_guard && !syn.wp_n);
	wire start_arr = cs_rise && (state == spi_eeprom_pkg::ST_WR_ARR)
		&& (bit_cnt[2:0] == 3'h0) && (|page_mask);
	wire start_sr = cs_rise && (state == spi_eeprom_pkg::ST_SR_DONE) && sr_ok;
	wire write_end = busy && (timer == 20'(write_cycles - 1));
	wire commit_en = busy && kind_arr && (timer < 20'(spi_eeprom_pkg::PAGE_BYTES))
		&& page_mask[timer[4:0]];

	// ****************************************
	// command decoder
	// ****************************************
	// next state, select high always returns to opcode phase
	always_comb begin
		next_state = state;
		if (syn.cs_n) begin
			next_state = spi_eeprom_pkg::ST_CMD;
		end else if (sh_in) begin
			case (state)
				spi_eeprom_pkg::ST_CMD: begin
					if (!byte_done) begin
						next_state = state;
					end else if (busy && next_byte != spi_eeprom_pkg::STATUS_READ_CMD) begin
						next_state = spi_eeprom_pkg::ST_IGNORE;
					end else if (next_byte == spi_eeprom_pkg::SET_WRITE_LATCH_CMD) begin
						next_state = spi_eeprom_pkg::ST_SET;
					end else if (next_byte == spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD) begin
						next_state = spi_eeprom_pkg::ST_CLR;
					end else if (next_byte == spi_eeprom_pkg::STATUS_WRITE_CMD) begin
						next_state = latch ? spi_eeprom_pkg::ST_WR_SR
							: spi_eeprom_pkg::ST_IGNORE;
					end else if (next_byte == spi_eeprom_pkg::STATUS_READ_CMD) begin
						next_state = spi_eeprom_pkg::ST_RD_SR;
					end else if (next_byte == spi_eeprom_pkg::ARRAY_READ_CMD) begin
						next_state = spi_eeprom_pkg::ST_ADDR;
					end else if (next_byte == spi_eeprom_pkg::ARRAY_WRITE_CMD) begin
						next_state = latch ? spi_eeprom_pkg::ST_ADDR
							: spi_eeprom_pkg::ST_IGNORE;
					end else begin
						next_state = spi_eeprom_pkg::ST_IGNORE; // unknown opcode
					end
				end
				// single byte commands and a completed status write spoil on any extra bit
				spi_eeprom_pkg::ST_SET, spi_eeprom_pkg::ST_CLR,
				spi_eeprom_pkg::ST_SR_DONE: next_state = spi_eeprom_pkg::ST_IGNORE;
				spi_eeprom_pkg::ST_ADDR: begin
					if (addr_done) begin
						next_state = cmd_wr ? spi_eeprom_pkg::ST_WR_ARR
							: spi_eeprom_pkg::ST_RD_ARR;
					end
				end
				spi_eeprom_pkg::ST_WR_SR: begin
					if (byte_done) begin
						next_state = spi_eeprom_pkg::ST_SR_DONE;
					end
				end
				default: next_state = state;
			endcase
		end
	end

	// state and bit counter, opcode field counter restarts for address
	always_ff @(posedge clk) begin
		if (rst || syn.cs_n) begin
			state <= spi_eeprom_pkg::ST_CMD;
			bit_cnt <= 4'h0;
		end else begin
			state <= next_state;
			if (sh_in) begin
				bit_cnt <= (state == spi_eeprom_pkg::ST_CMD && byte_done) ? 4'h0
					: bit_cnt + 4'h1;
			end
		end
	end

	// ****************************************
	// data path
	// ****************************************
	// input shifter, load of read data, write pointer, output shifter
	always_ff @(posedge clk) begin
		if (rst) begin
			in_sr <= 16'h0000;
			out_sr <= 8'h00;
			so <= 1'b0;
			cmd_wr <= 1'b0;
			rd_ptr <= 11'h000;
			wr_addr <= 11'h000;
			page_mask <= 32'h00000000;
			sr_new <= 8'h00;
		end else if (sh_in) begin
			in_sr <= next_word;
			case (state)
				spi_eeprom_pkg::ST_CMD: begin
					if (byte_done) begin
						cmd_wr <= (next_byte == spi_eeprom_pkg::ARRAY_WRITE_CMD);
						out_sr <= status_byte;
					end
				end
				spi_eeprom_pkg::ST_ADDR: begin
					if (addr_done && cmd_wr) begin
						wr_addr <= rx_addr;
						page_mask <= 32'h00000000;
					end else if (addr_done) begin
						out_sr <= mem[rx_addr];
						rd_ptr <= spi_eeprom_pkg::mask_addr({5'h00, rx_addr} + 16'h0001,
							big_variant);
					end
				end
				spi_eeprom_pkg::ST_RD_ARR: begin
					if (byte_done) begin
						out_sr <= mem[rd_ptr]; // whole array rolls over
						rd_ptr <= rd_next;
					end
				end
				spi_eeprom_pkg::ST_RD_SR: begin
					if (byte_done) begin
						out_sr <= status_byte; // repeats while clocked
					end
				end
				spi_eeprom_pkg::ST_WR_ARR: begin
					if (byte_done) begin
						if (!wr_prot) begin
							page_mask[wr_addr[4:0]] <= 1'b1;
						end
						wr_addr[4:0] <= wr_addr[4:0] + 5'h01; // page fixed, offset wraps
					end
				end
				spi_eeprom_pkg::ST_WR_SR: begin
					if (byte_done) begin
						sr_new <= next_byte;
					end
				end
				default: begin
					sr_new <= sr_new;
				end
			endcase
		end else if (sh_out) begin
			so <= out_sr[7];
			out_sr <= {out_sr[6:0], 1'b0};
		end
	end

	// output enabled only in read phases while selected, not paused
	assign so_oe = active && (state == spi_eeprom_pkg::ST_RD_ARR
		|| state == spi_eeprom_pkg::ST_RD_SR);

	// page buffer fill, protected bytes never reach it
	always_ff @(posedge clk) begin
		if (sh_in && state == spi_eeprom_pkg::ST_WR_ARR && byte_done && !wr_prot) begin
			page_buf[wr_addr[4:0]] <= next_byte;
		end
	end

	// array programming, one buffered byte per cycle early in the cycle
	always_ff @(posedge clk) begin
		if (commit_en) begin
			mem[{wr_addr[10:5], timer[4:0]}] <= page_buf[timer[4:0]];
		end
	end

	// ****************************************
	// status register and write cycle
	// ****************************************
	// latch, guard bits, busy timer
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_guard <= spi_eeprom_pkg::PIN_GUARD_RST;
			bp <= spi_eeprom_pkg::BLOCK_GUARD_RST;
			latch <= spi_eeprom_pkg::WRITE_LATCH_RST;
			busy <= 1'b0;
			kind_arr <= 1'b0;
			timer <= 20'h00000;
		end else if (start_arr || start_sr) begin
			busy <= 1'b1;
			kind_arr <= start_arr;
			timer <= 20'h00000;
			if (start_sr) begin
				pin_guard <= sr_new[spi_eeprom_pkg::PIN_GUARD_ENABLE_POS];
				bp <= {sr_new[spi_eeprom_pkg::BLOCK_GUARD_HI_POS],
					sr_new[spi_eeprom_pkg::BLOCK_GUARD_LO_POS]};
			end
		end else if (write_end) begin
			busy <= 1'b0;
			latch <= 1'b0;
		end else if (busy) begin
			timer <= timer + 20'h00001;
		end else if (cs_rise && state == spi_eeprom_pkg::ST_SET) begin
			latch <= 1'b1;
		end else if (cs_rise && state == spi_eeprom_pkg::ST_CLR) begin
			latch <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_set_frame;
		cs_rise && state == spi_eeprom_pkg::ST_SET && !busy;
	endsequence
	sequence s_guarded_sr_end;
		cs_rise && state == spi_eeprom_pkg::ST_SR_DONE && pin_guard && !syn.wp_n;
	endsequence

	property p_cs_hiz;
		syn.cs_n |-> !so_oe;
	endproperty
	a_cs_hiz: assert property (p_cs_hiz) else $error("output on while deselected");

	property p_hold_hiz;
		!syn.hold_n |-> !so_oe;
	endproperty
	a_hold_hiz: assert property (p_hold_hiz) else $error("output on while paused");

	property p_so_on_fall;
		$changed(so) |-> $past(sh_out);
	endproperty
	a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off fall");

	property p_sample_rise;
		sh_in |=> in_sr[0] == $past(syn.si);
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("input bit not taken");

	property p_busy_ignore;
		busy && state == spi_eeprom_pkg::ST_CMD && byte_done
			&& next_byte != spi_eeprom_pkg::STATUS_READ_CMD |=> state == spi_eeprom_pkg::ST_IGNORE;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

	property p_latch_needed;
		state == spi_eeprom_pkg::ST_CMD && byte_done && !latch
			&& next_byte == spi_eeprom_pkg::ARRAY_WRITE_CMD |=> state == spi_eeprom_pkg::ST_IGNORE;
	endproperty
	a_latch_needed: assert property (p_latch_needed) else $error("write without latch");

	property p_write_start;
		$rose(busy) |-> $past(cs_rise);
	endproperty
	a_write_start: assert property (p_write_start) else $error("write began mid frame");

	property p_latch_end;
		$fell(busy) |-> !latch ##1 !latch;
	endproperty
	a_latch_end: assert property (p_latch_end) else $error("latch kept after write");

	// length of the current busy stretch, counted apart from the write timer
	logic [19:0] busy_len;
	always_ff @(posedge clk) begin
		if (rst || !busy) begin
			busy_len <= 20'h00000; // idle or reset, nothing running
		end else begin
			busy_len <= busy_len + 20'h00001; // one more busy cycle
		end
	end

	property p_busy_bound;
		busy |-> busy_len < 20'(write_cycles);
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("write cycle too long");

	property p_guard_refuse;
		s_guarded_sr_end |=> !busy && $stable(bp);
	endproperty
	a_guard_refuse: assert property (p_guard_refuse) else $error("guarded status written");

	property p_latch_set;
		s_set_frame |=> latch;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch not set");

	property p_page_wrap;
		state == spi_eeprom_pkg::ST_WR_ARR && byte_done |=>
			wr_addr[10:5] == $past(wr_addr[10:5]) && wr_addr[4:0] == $past(wr_addr[4:0]) + 5'h01;
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page offset step wrong");

endmodule : spi_eeprom_command_protect

`default_nettype wire

//--- testbench/spi_host_model.sv
// host side master model that drives the serial eeprom pins
// assumes the bench clk; every pin change lands on a clk rising edge
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic hold_n,
	output logic wp_n,
	input wire logic so_wire,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic off_probe
);
	// ****************************************
	// state and idle levels
	// ****************************************
	logic cpol; // sck idle level: 0 mode (0,0), 1 mode (1,1)
	logic [7:0] shift; // bits taken from the output line

	// deselected, pause released, protect high
	initial begin
		cpol = 1'b0;
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		wp_n = 1'b1;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		off_probe = 1'b0;
	end

	// released data line wiggles so a stale bit is never mistaken for a sent one
	always @(posedge clk) begin
		if (cs_n) begin
			si <= ~si;
		end
	end

	// ****************************************
	// framing and byte transfer
	// ****************************************
	// select falls with sck already at its idle level
	task automatic frame_begin();
		sck <= cpol;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : frame_begin

	// sck back to idle, then select rises; output must then be off
	task automatic frame_end();
		sck <= cpol;
		repeat (6) @(posedge clk);
		cs_n <= 1'b1;
		repeat (5) @(posedge clk);
		off_probe <= 1'b1;
		@(posedge clk);
		off_probe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : frame_end

	// one byte each way, msb first; pauses inside bit pause_at when 0..7
	task automatic xfer(input logic [7:0] tx, input logic chk, input int pause_at);
		for (int b = 7; b >= 0; b--) begin
			sck <= 1'b0;
			si <= tx[b]; // data set while sck low
			repeat (6 + b % 2) @(posedge clk);
			if (b == pause_at) begin
				hold_n <= 1'b0; // sck is low here
				repeat (6) @(posedge clk);
				sck <= 1'b1; // stray edge and data, to be ignored
				si <= ~tx[b];
				repeat (6) @(posedge clk);
				sck <= 1'b0;
				off_probe <= 1'b1;
				@(posedge clk);
				off_probe <= 1'b0;
				si <= tx[b];
				repeat (6) @(posedge clk);
				hold_n <= 1'b1; // resumed with sck low
				repeat (6) @(posedge clk);
			end
			shift[b] = so_wire; // taken at the rise
			sck <= 1'b1;
			repeat (6) @(posedge clk);
		end
		rx_byte <= shift;
		rx_valid <= chk;
		@(posedge clk);
		rx_valid <= 1'b0;
	endtask : xfer

endmodule : spi_host_model
`default_nettype wire

//--- testbench/spi_eeprom_command_protect_tb.sv
// self-checking bench for the serial eeprom command and protection block
// assumes the host model drives every pin; clk 100 MHz, sck about 125 ns
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_protect_tb;
	localparam int WCYC = 1000; // shortened write cycle
	localparam int LIMIT = 95000; // cycle ceiling for the whole run
	logic clk;
	logic rst;
	wire logic cs_n;
	wire logic sck;
	wire logic si;
	wire logic hold_n;
	wire logic wp_n;
	wire logic so_w;
	logic so;
	logic so_oe;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic off_probe;
	int miscompares;
	int total_checks;
	int cycles;
	logic [7:0] exp_q[$]; // bytes the host should read, oldest first
	logic [7:0] ref_mem[0:2047]; // expected array contents
	logic [15:0] edge_addr[6] = '{16'h0000, 16'h03FF, 16'h0400, 16'hF5FF, 16'h0600, 16'h07FF};

	assign so_w = so_oe ? so : 1'bz; // released output floats

	spi_eeprom_command_protect #(.big_variant(1'b1), .write_cycles(WCYC)) DUT (.clk(clk),
		.rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
		.so_oe(so_oe));
	spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
		.wp_n(wp_n), .so_wire(so_w), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.off_probe(off_probe));

	// ****************************************
	// comparison and reporting
	// ****************************************
	task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : compare_byte

	task automatic check_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: output enable %b, expected %b", $time, got, exp);
		end
	endtask : check_flag

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// each byte read with rx_valid set is checked against the oldest note
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			compare_byte(rx_byte, exp_q.pop_front());
		end
		if (off_probe === 1'b1) begin
			check_flag(so_oe, 1'b0);
		end
	end

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			$display("mismatch at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	// ****************************************
	// host level operations
	// ****************************************
	task automatic send(input logic [7:0] op);
		host.frame_begin();
		host.xfer(op, 1'b0, -1);
		host.frame_end();
	endtask : send

	task automatic status_is(input logic [7:0] e);
		host.frame_begin();
		host.xfer(spi_eeprom_pkg::STATUS_READ_CMD, 1'b0, -1);
		exp_q.push_back(e);
		host.xfer(8'($urandom), 1'b1, -1);
		host.frame_end();
	endtask : status_is

	task automatic wr_status(input logic [7:0] v);
		send(spi_eeprom_pkg::SET_WRITE_LATCH_CMD);
		host.frame_begin();
		host.xfer(spi_eeprom_pkg::STATUS_WRITE_CMD, 1'b0, -1);
		host.xfer(v, 1'b0, -1);
		host.frame_end();
	endtask : wr_status

	// poll status in one frame until the busy flag drops, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		host.frame_begin();
		host.xfer(spi_eeprom_pkg::STATUS_READ_CMD, 1'b0, -1);
		do begin
			host.xfer(8'h00, 1'b0, -1);
			n++;
		end while (rx_byte[0] !== 1'b0 && n < 100);
		host.frame_end();
		check_flag(n < 100, 1'b1);
	endtask : wait_ready

	// write n random bytes; ok says whether the device must keep them
	task automatic write_arr(input logic [15:0] a, input int n, input logic ok, input int pz);
		logic [7:0] d;
		logic [4:0] off;
		host.frame_begin();
		host.xfer(spi_eeprom_pkg::ARRAY_WRITE_CMD, 1'b0, -1);
		host.xfer(a[15:8], 1'b0, -1);
		host.xfer(a[7:0], 1'b0, -1);
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			off = a[4:0] + 5'(k);
			host.xfer(d, 1'b0, (k == 1) ? pz : -1);
			if (ok) ref_mem[{a[10:5], off}] = d;
		end
		host.frame_end();
	endtask : write_arr

	task automatic read_arr(input logic [15:0] a, input int n, input int pz);
		host.frame_begin();
		host.xfer(spi_eeprom_pkg::ARRAY_READ_CMD, 1'b0, -1);
		host.xfer(a[15:8], 1'b0, -1);
		host.xfer(a[7:0], 1'b0, -1);
		for (int k = 0; k < n; k++) begin
			exp_q.push_back(ref_mem[a[10:0] + 11'(k)]);
			host.xfer(8'($urandom), 1'b1, (k == 1) ? pz : -1);
		end
		host.frame_end();
	endtask : read_arr

	function automatic logic guarded(input int bp, input logic [15:0] a);
		if (bp == 1) return a[10:0] >= 11'h600;
		if (bp == 2) return a[10:0] >= 11'h400;
		return bp == 3;
	endfunction : guarded

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		miscompares = 0;
		total_checks = 0;
		cycles = 0;
		void'($urandom(32'h5F9B));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		status_is(8'h00);
		send(spi_eeprom_pkg::SET_WRITE_LATCH_CMD);
		status_is(8'h02);
		send(spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD);
		status_is(8'h00);
		write_arr(16'h0123, 1, 1'b0, -1);
		status_is(8'h00); // no latch, no write cycle
		$display("test latch done");
		send(spi_eeprom_pkg::SET_WRITE_LATCH_CMD);
		write_arr(16'hFFE3, 34, 1'b1, 3);
		status_is(8'h03);
		write_arr(16'h07E5, 1, 1'b0, -1); // ignored while busy
		wait_ready();
		status_is(8'h00);
		read_arr(16'h07E0, 32, 2);
		$display("test page done");
		host.cpol = 1'b1; // mode (1,1) from here on
		for (int bp = 0; bp < 4; bp++) begin
			wr_status(8'h73 | 8'(bp << 2));
			wait_ready();
			status_is(8'(bp << 2));
			foreach (edge_addr[j]) begin
				send(spi_eeprom_pkg::SET_WRITE_LATCH_CMD);
				write_arr(edge_addr[j], 1, !guarded(bp, edge_addr[j]), -1);
				wait_ready();
				read_arr(edge_addr[j], 1, -1);
			end
		end
		$display("test block guard done");
		host.wp_n <= 1'b0;
		wr_status(8'h80);
		wait_ready();
		status_is(8'h80); // guard clear, pin low allowed
		wr_status(8'h0C);
		status_is(8'h82); // refused
		host.wp_n <= 1'b1;
		wr_status(8'h0C);
		wait_ready();
		status_is(8'h0C); // pin high allows
		$display("test pin guard done");
		host.frame_begin();
		host.xfer(8'hA5, 1'b0, -1);
		host.xfer(8'h00, 1'b0, 3); // output stays off
		host.frame_end();
		status_is(8'h0C);
		$display("test unknown opcode done");
		tally_and_finish();
	end

endmodule : spi_eeprom_command_protect_tb
`default_nettype wire
